// ===== pkg/bao_exec_if.sv
`timescale 1ns/10ps
interface bao_exec_if;
    import bao_pkg::*;
    // Operands from the core
    bao_op_t op;
    logic dest;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] file_val;
    logic [DATA_W-1:0] literal;
    logic carry_in;
    // Results from the datapath
    logic [DATA_W-1:0] result;
    logic carry_out;
    logic half_carry_out;
    logic zero_out;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic wr_acc;
    logic wr_file;

    modport core (
        output op, dest, acc, file_val, literal, carry_in,
        input result, carry_out, half_carry_out, zero_out,
        input upd_c, upd_dc, upd_z, wr_acc, wr_file
    );
    modport alu (
        input op, dest, acc, file_val, literal, carry_in,
        output result, carry_out, half_carry_out, zero_out,
        output upd_c, upd_dc, upd_z, wr_acc, wr_file
    );
endinterface : bao_exec_if

// ===== pkg/bao_pkg.sv
package bao_pkg;

    // ------------------------------------------------------------
    // Datapath widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int NIB_W = 4;

    // ------------------------------------------------------------
    // APB register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_EXEC = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_FADDR = 8'h0C;
    localparam logic [7:0] REG_FDATA = 8'h10;
    localparam logic [7:0] REG_WDOG = 8'h14;
    localparam logic [7:0] REG_WAKE = 8'h18;

    // ------------------------------------------------------------
    // Instruction word layout in the execute register
    // ------------------------------------------------------------
    localparam int LIT_LSB = 0;
    localparam int FA_LSB = 8;
    localparam int DEST_BIT = 15;
    localparam int OP_LSB = 16;
    localparam int OP_W = 3;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // ------------------------------------------------------------
    // Status, watchdog and wake register bit positions and status reset values
    // ------------------------------------------------------------
    localparam int ST_C = 0;
    localparam int ST_HC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PWRDN = 3;
    localparam int ST_EXPIRY = 4;
    localparam int ST_SLEEP = 5;
    localparam logic PWRDN_RESET = 1'b1;
    localparam logic EXPIRY_RESET = 1'b1;
    localparam int WDOG_PRE_LSB = 8;
    localparam int WAKE_BIT = 0;

    // ------------------------------------------------------------
    // Watchdog timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int WDOG_TICK_NS = 1000;
    localparam int WDOG_TICK_CYCLES = WDOG_TICK_NS / CLK_PERIOD_NS;
    localparam int WDOG_PRESCALE = 256;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;

    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [OP_W-1:0] {
        no_op,
        power_down_op,
        rotate_right_carry_op,
        literal_minus_acc_op,
        file_minus_acc_op,
        xor_file_op,
        xor_literal_op,
        nibble_exchange_op
    } bao_op_t;

endpackage : bao_pkg

// ===== test/bao_core_assertions.sv
`timescale 1ns/10ps
module bao_core_checker
    import bao_pkg::*;
#(
    parameter int TICK_CYCLES = WDOG_TICK_CYCLES,
    parameter int PRESCALE = WDOG_PRESCALE
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_halt
);
    // ----------------------------------------
    // Transfer decode
    // ----------------------------------------
    // Status capture happens at the setup edge, so sleep state is judged one cycle back
    logic wr_go;
    logic rd_go;
    logic rd_setup;
    logic pwrdn_go;
    logic st_rd;
    assign wr_go = psel && penable && pwrite;
    assign rd_go = psel && penable && !pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pwrdn_go = wr_go && paddr == REG_EXEC && pwdata[OP_LSB +: OP_W] == power_down_op
        && !osc_halt;
    assign st_rd = rd_go && paddr == REG_STATUS;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // A power-down coinciding with a watchdog wrap is not expected here
    a_halt_on_pwrdn: assert property (pwrdn_go |=> osc_halt)
        else $error("sleep not entered after power-down");
    a_wake_resumes: assert property (wr_go && paddr == REG_WAKE && pwdata[WAKE_BIT] && osc_halt
        |=> !osc_halt) else $error("wake did not leave sleep");
    a_wdog_zeroed: assert property (pwrdn_go ##1 (rd_setup && paddr == REG_WDOG)
        |=> prdata == 32'h0000_0000) else $error("watchdog not cleared");
    a_pwrdn_cleared: assert property (st_rd && $past(osc_halt) |-> !prdata[ST_PWRDN])
        else $error("power-down flag set while asleep");
    a_expiry_set: assert property (st_rd && $past(osc_halt) |-> prdata[ST_EXPIRY])
        else $error("expiry flag clear while asleep");
    a_sleep_bit: assert property (st_rd |-> prdata[ST_SLEEP] == $past(osc_halt))
        else $error("sleep bit differs from halt");
    a_acc_readback: assert property (wr_go && paddr == REG_ACC ##1 (rd_setup && paddr == REG_ACC)
        |=> prdata == ($past(pwdata, 2) & 32'h0000_00FF)) else $error("acc readback");
    a_exec_readback: assert property (wr_go && paddr == REG_EXEC && !osc_halt
        ##1 (rd_setup && paddr == REG_EXEC) |=> prdata == ($past(pwdata, 2) & 32'h0007_FFFF))
        else $error("exec word readback");

    c_power_down: cover property (pwrdn_go);
    c_wake: cover property (wr_go && paddr == REG_WAKE && osc_halt);
    c_refused: cover property (pready && pslverr);
    c_leave_sleep: cover property (osc_halt ##1 !osc_halt);
endmodule : bao_core_checker

bind bao_core bao_core_checker #(.TICK_CYCLES(TICK_CYCLES), .PRESCALE(PRESCALE)) u_chk (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_halt(osc_halt));

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
    import bao_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_halt;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    // Short watchdog so a timeout would come within the run
    bao_core #(.TICK_CYCLES(2), .PRESCALE(2)) dut (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_halt(osc_halt));

    always #4 clock = ~clock;

    // ----------------------------------------
    // Reporting and hang guard
    // ----------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Leaves psel up so the next transfer follows at once; idle drops it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask : xfer

    task automatic idle;
        psel <= 1'b0;
        @(posedge clock);
    endtask : idle

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp, what);
    endtask : rd_chk

    // Loads operands, runs one instruction and checks both destinations and the flags
    task automatic run_op(input bao_op_t op, input logic dest, input logic [6:0] fa,
        input logic [7:0] a, input logic [7:0] f, input logic [7:0] k, input logic [2:0] st);
        logic [7:0] res;
        logic [7:0] src;
        logic [2:0] ns;
        logic [31:0] word;
        ns = st;
        src = (op == literal_minus_acc_op || op == xor_literal_op) ? k : f;
        case (op)
            rotate_right_carry_op: begin
                res = {st[ST_C], f[7:1]};
                ns[ST_C] = f[0];
            end
            literal_minus_acc_op, file_minus_acc_op: begin
                res = src - a;
                ns[ST_C] = a <= src;
                ns[ST_HC] = a[3:0] <= src[3:0];
                ns[ST_Z] = res == 8'h00;
            end
            xor_file_op, xor_literal_op: begin
                res = a ^ src;
                ns[ST_Z] = res == 8'h00;
            end
            default: res = {f[3:0], f[7:4]};
        endcase
        word = {13'h0000, op, dest, fa, k};
        xfer(1'b1, REG_FADDR, {25'h000_0000, fa});
        xfer(1'b1, REG_FDATA, {24'h00_0000, f});
        xfer(1'b1, REG_ACC, {24'h00_0000, a});
        xfer(1'b1, REG_STATUS, {29'h0000_0000, st});
        xfer(1'b1, REG_EXEC, word);
        rd_chk(REG_EXEC, word, "exec word");
        rd_chk(REG_ACC, {24'h00_0000, (dest == DEST_FILE) ? a : res}, "accumulator");
        rd_chk(REG_FDATA, {24'h00_0000, (dest == DEST_FILE) ? res : f}, "file register");
        xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check({29'h0000_0000, rd[2:0]}, {29'h0000_0000, ns}, "flags");
    endtask : run_op

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd_chk(REG_ACC, 32'h0000_0000, "acc after reset");
        rd_chk(REG_STATUS, 32'h0000_0018, "status after reset");
        xfer(1'b1, REG_ACC, 32'h0000_005A);
        rd_chk(REG_ACC, 32'h0000_005A, "acc written");
        xfer(1'b0, 8'h40, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001, "unmapped refused");
        idle();
    endtask : t_reset

    task automatic t_rotate;
        run_op(rotate_right_carry_op, DEST_ACC, 7'h7F, 8'hAA, 8'h01, 8'h00, 3'b110);
        run_op(rotate_right_carry_op, DEST_FILE, 7'h00, 8'h55, 8'h80, 8'h00, 3'b001);
    endtask : t_rotate

    // Below, equal and low-nibble borrow cases for both subtractions
    task automatic t_sub;
        logic [15:0] tab [4] = '{16'h0305, 16'h0503, 16'h0110, 16'h3333};
        for (int i = 0; i < 4; i++) begin
            run_op(literal_minus_acc_op, DEST_ACC, 7'h11, tab[i][15:8], 8'h99, tab[i][7:0],
                3'b000);
            run_op(file_minus_acc_op, i[0], 7'h22, tab[i][15:8], tab[i][7:0], 8'h00,
                3'b111);
        end
    endtask : t_sub

    task automatic t_xor;
        run_op(xor_file_op, DEST_FILE, 7'h05, 8'h3C, 8'h3C, 8'h00, 3'b011);
        run_op(xor_file_op, DEST_ACC, 7'h06, 8'hF0, 8'h0F, 8'h00, 3'b100);
        run_op(xor_literal_op, DEST_ACC, 7'h07, 8'hA5, 8'h00, 8'hFF, 3'b100);
        run_op(xor_literal_op, DEST_ACC, 7'h07, 8'h81, 8'h00, 8'h81, 3'b011);
    endtask : t_xor

    task automatic t_swap;
        run_op(nibble_exchange_op, DEST_ACC, 7'h40, 8'h00, 8'h1E, 8'h00, 3'b111);
        run_op(nibble_exchange_op, DEST_FILE, 7'h41, 8'h00, 8'hF0, 8'h00, 3'b010);
    endtask : t_swap

    task automatic t_sleep;
        xfer(1'b1, REG_EXEC, 32'h0001_0000);
        rd_chk(REG_WDOG, 32'h0000_0000, "watchdog cleared");
        check({31'h0, osc_halt}, 32'h0000_0001, "oscillator halted");
        xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check({29'h0, rd[5:3]}, 32'h0000_0006, "sleep flags");
        xfer(1'b1, REG_WAKE, 32'h0000_0001);
        idle();
        @(negedge clock);
        check({31'h0, osc_halt}, 32'h0000_0000, "awake again");
    endtask : t_sleep

    // Asleep: execution is refused and, with no wake write, a watchdog wrap wakes the core
    task automatic t_timeout;
        @(posedge clock);
        xfer(1'b1, REG_ACC, 32'h0000_003C);
        xfer(1'b1, REG_EXEC, 32'h0001_0000);
        xfer(1'b1, REG_EXEC, {13'h0000, xor_literal_op, DEST_ACC, 7'h00, 8'hFF});
        rd_chk(REG_ACC, 32'h0000_003C, "exec refused asleep");
        idle();
        // Wrap needs 2*2*256 cycles from the clear, one more to wake
        repeat (1016) @(posedge clock);
        @(negedge clock);
        check({31'h0, osc_halt}, 32'h0000_0001, "asleep before wrap");
        repeat (8) @(posedge clock);
        xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check({29'h0, rd[5:3]}, 32'h0000_0000, "woken by watchdog");
        check({31'h0, osc_halt}, 32'h0000_0000, "awake after wrap");
        idle();
    endtask : t_timeout

    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        t_reset();
        t_rotate();
        t_sub();
        t_xor();
        t_swap();
        t_sleep();
        t_timeout();
        end_sim();
    end
endmodule : tb

// ===== verilog/bao_alu.sv
`timescale 1ns/10ps
module bao_alu
    import bao_pkg::*;
(
    bao_exec_if.alu x
);
    logic [DATA_W-1:0] minuend;
    logic [DATA_W:0] diff;

    // ------------------------------------------------------------
    // Result and flag generation, one instruction per call
    // ------------------------------------------------------------
    always_comb begin
        minuend = (x.op == literal_minus_acc_op) ? x.literal : x.file_val;
        diff = {1'b0, minuend} - {1'b0, x.acc};
        x.result = x.acc;
        x.carry_out = x.carry_in;
        x.half_carry_out = 1'b0;
        x.upd_c = 1'b0;
        x.upd_dc = 1'b0;
        x.upd_z = 1'b0;
        x.wr_acc = 1'b0;
        x.wr_file = 1'b0;
        unique case (x.op)
            rotate_right_carry_op: begin
                x.result = {x.carry_in, x.file_val[DATA_W-1:1]};
                x.carry_out = x.file_val[0];
                x.upd_c = 1'b1;
            end
            literal_minus_acc_op, file_minus_acc_op: begin
                x.result = diff[DATA_W-1:0];
                // Borrow out inverted: clear only when acc is larger
                x.carry_out = (x.acc <= minuend);
                x.half_carry_out = (x.acc[NIB_W-1:0] <= minuend[NIB_W-1:0]);
                x.upd_c = 1'b1;
                x.upd_dc = 1'b1;
                x.upd_z = 1'b1;
            end
            xor_file_op: begin
                x.result = x.acc ^ x.file_val;
                x.upd_z = 1'b1;
            end
            xor_literal_op: begin
                x.result = x.acc ^ x.literal;
                x.upd_z = 1'b1;
            end
            nibble_exchange_op: begin
                x.result = {x.file_val[NIB_W-1:0], x.file_val[DATA_W-1:NIB_W]};
            end
            power_down_op, no_op: begin
                x.result = x.acc;
            end
        endcase
        x.zero_out = (x.result == '0);
        // Literal forms always land in the accumulator
        if (x.op == literal_minus_acc_op || x.op == xor_literal_op) begin
            x.wr_acc = 1'b1;
        end else if (x.op != no_op && x.op != power_down_op) begin
            x.wr_acc = (x.dest == DEST_ACC);
            x.wr_file = (x.dest == DEST_FILE);
        end
    end

endmodule : bao_alu

// ===== verilog/bao_core.sv
`timescale 1ns/10ps
module bao_core
    import bao_pkg::*;
#(
    parameter int TICK_CYCLES = WDOG_TICK_CYCLES,
    parameter int PRESCALE = WDOG_PRESCALE
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic osc_halt
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic {
        run_st,
        sleep_st
    } bao_run_t;

    typedef struct packed {
        logic [FILE_DEPTH-1:0][DATA_W-1:0] fregs;
        logic [DATA_W-1:0] acc;
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic power_down_flag;
        logic watchdog_expiry_flag;
        bao_run_t run;
        logic [FADDR_W-1:0] faddr;
        logic [31:0] instr;
        logic [31:0] rdata;
    } bao_core_st_t;

    bao_core_st_t s;
    bao_core_st_t next_s;

    bao_exec_if x ();

    logic acc_write;
    logic acc_setup;
    logic mapped;
    logic go;
    logic wdog_clear;
    logic wdog_timeout;
    logic [DATA_W-1:0] watchdog_counter;
    logic [DATA_W-1:0] wdog_pre;
    logic [FADDR_W-1:0] op_faddr;
    logic [31:0] rd_word;

    // ------------------------------------------------------------
    // Datapath and watchdog
    // ------------------------------------------------------------
    bao_alu u_alu (
        .x(x.alu)
    );

    bao_wdog #(
        .TICK_CYCLES(TICK_CYCLES),
        .PRESCALE(PRESCALE)
    ) u_wdog (
        .clock(clock),
        .rstn(rstn),
        .clear(wdog_clear),
        .count(watchdog_counter),
        .prescale(wdog_pre),
        .timeout(wdog_timeout)
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Zero wait states: the access phase always completes at once
    assign pready = psel & penable;
    assign acc_write = psel & penable & pwrite;
    assign acc_setup = psel & ~penable;

    always_comb begin
        unique case (paddr)
            REG_EXEC, REG_ACC, REG_STATUS, REG_FADDR,
            REG_FDATA, REG_WDOG, REG_WAKE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = pready & ~mapped;

    // ------------------------------------------------------------
    // Operands: instruction fields fed straight from the write data; acc, file value and carry from state
    // ------------------------------------------------------------
    // The datapath sees the new instruction in its own write cycle,
    // so execution costs no extra bus cycle
    assign op_faddr = pwdata[FA_LSB +: FADDR_W];
    assign x.op = bao_op_t'(pwdata[OP_LSB +: OP_W]);
    assign x.dest = pwdata[DEST_BIT];
    assign x.literal = pwdata[LIT_LSB +: DATA_W];
    assign x.acc = s.acc;
    assign x.file_val = s.fregs[op_faddr];
    assign x.carry_in = s.carry;

    // Execution is refused while asleep; the write is then dropped
    assign go = acc_write & (paddr == REG_EXEC) & (s.run == run_st);
    assign wdog_clear = go & (x.op == power_down_op);

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        unique case (paddr)
            REG_EXEC: rd_word = s.instr;
            REG_ACC: rd_word[DATA_W-1:0] = s.acc;
            REG_STATUS: begin
                rd_word[ST_C] = s.carry;
                rd_word[ST_HC] = s.half_carry_flag;
                rd_word[ST_Z] = s.zero;
                rd_word[ST_PWRDN] = s.power_down_flag;
                rd_word[ST_EXPIRY] = s.watchdog_expiry_flag;
                rd_word[ST_SLEEP] = (s.run == sleep_st);
            end
            REG_FADDR: rd_word[FADDR_W-1:0] = s.faddr;
            REG_FDATA: rd_word[DATA_W-1:0] = s.fregs[s.faddr];
            REG_WDOG: begin
                rd_word[DATA_W-1:0] = watchdog_counter;
                rd_word[WDOG_PRE_LSB +: DATA_W] = wdog_pre;
            end
            default: rd_word = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Read data is caught in the setup cycle so it leaves a flop
        if (acc_setup && !pwrite) begin
            next_s.rdata = rd_word;
        end
        // Instruction execution
        if (go) begin
            next_s.instr = pwdata;
            if (x.upd_c) begin
                next_s.carry = x.carry_out;
            end
            if (x.upd_dc) begin
                next_s.half_carry_flag = x.half_carry_out;
            end
            if (x.upd_z) begin
                next_s.zero = x.zero_out;
            end
            if (x.wr_acc) begin
                next_s.acc = x.result;
            end
            if (x.wr_file) begin
                next_s.fregs[op_faddr] = x.result;
            end
            if (x.op == power_down_op) begin
                next_s.power_down_flag = 1'b0;
                next_s.watchdog_expiry_flag = 1'b1;
                next_s.run = sleep_st;
            end
        end
        // Direct software access to core state
        if (acc_write) begin
            unique case (paddr)
                REG_ACC: next_s.acc = pwdata[DATA_W-1:0];
                REG_STATUS: begin
                    next_s.carry = pwdata[ST_C];
                    next_s.half_carry_flag = pwdata[ST_HC];
                    next_s.zero = pwdata[ST_Z];
                end
                REG_FADDR: next_s.faddr = pwdata[FADDR_W-1:0];
                REG_FDATA: next_s.fregs[s.faddr] = pwdata[DATA_W-1:0];
                REG_WAKE: begin
                    if (pwdata[WAKE_BIT]) begin
                        next_s.run = run_st;
                    end
                end
                default: next_s.run = next_s.run;
            endcase
        end
        // A watchdog expiry wakes the core and marks the cause;
        // being a hardware event it wins over any same-cycle set
        if (wdog_timeout) begin
            next_s.watchdog_expiry_flag = 1'b0;
            next_s.run = run_st;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= '0;
            s.power_down_flag <= PWRDN_RESET;
            s.watchdog_expiry_flag <= EXPIRY_RESET;
            s.run <= run_st;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s.rdata;
    // Oscillator gate request; the clock itself stays with the caller
    assign osc_halt = (s.run == sleep_st);

endmodule : bao_core

// ===== verilog/bao_wdog.sv
`timescale 1ns/10ps
module bao_wdog
    import bao_pkg::*;
#(
    parameter int TICK_CYCLES = WDOG_TICK_CYCLES,
    parameter int PRESCALE = WDOG_PRESCALE
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clear,
    output logic [DATA_W-1:0] count,
    output logic [DATA_W-1:0] prescale,
    output logic timeout
);
    typedef struct packed {
        logic [15:0] div;
        logic [DATA_W-1:0] pre;
        logic [DATA_W-1:0] cnt;
        logic tmo;
    } bao_wdog_st_t;

    bao_wdog_st_t s;
    bao_wdog_st_t next_s;
    logic tick;

    // ------------------------------------------------------------
    // Tick divider, prescaler and counter
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.tmo = 1'b0;
        tick = (s.div == 16'(TICK_CYCLES - 1));
        next_s.div = tick ? '0 : s.div + 16'h0001;
        if (tick) begin
            if (s.pre == DATA_W'(PRESCALE - 1)) begin
                next_s.pre = '0;
                next_s.cnt = s.cnt + 8'h01;
                next_s.tmo = (s.cnt == 8'hFF);
            end else begin
                next_s.pre = s.pre + 8'h01;
            end
        end
        // Clear wins over a tick in the same cycle
        if (clear) begin
            next_s.cnt = WDOG_CLEAR;
            next_s.pre = WDOG_CLEAR;
            next_s.div = '0;
            next_s.tmo = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign count = s.cnt;
    assign prescale = s.pre;
    assign timeout = s.tmo;

endmodule : bao_wdog
